// ### design/nv_access_defs.vh
/*
 Constants for the nonvolatile access controller: I/O offsets, control bit
 positions, reset values and timing counts.
 Assumes inclusion by bare name from the design files.
*/
`ifndef NV_ACCESS_DEFS_VH
`define NV_ACCESS_DEFS_VH

`define IO_DIRECT_MAX 8'h3f
`define IO_BIT_MAX 8'h1f
`define IO_MEM_OFFSET 8'h20
`define IO_EXT_LO 8'h60
`define IO_EXT_HI 8'hff
`define OFF_DATA_BYTE 8'h20
`define OFF_ADDR_LOW 8'h21
`define OFF_ADDR_HIGH 8'h22
`define OFF_CONTROL 8'h1f

`define CTL_READ_BIT 0
`define CTL_WRITE_BIT 1
`define CTL_ARM_BIT 2
`define CTL_IRQEN_BIT 3

`define ADDR_BITS_SMALL 9
`define ADDR_BITS_LARGE 11
`define ADDR_BITS_MAX 11

`define ARM_WINDOW_CYCLES 3'h4
`define READ_STALL_CYCLES 3'h4
`define WRITE_STALL_CYCLES 3'h2
`define PROG_RC_CYCLES 27072
`define RC_DIV_LAST 2'h1
`define PROG_LAST_TICK 15'h69bf

`define CTL_RESET 8'h00
`define DATA_RESET 8'h00

`endif

// ### design/nv_stall_timer.v
/*
 Countdown used to hold the processor for a fixed number of cycles.
 Assumes load is a one-cycle pulse from the controller, whose own output flop
 covers the first stall cycle, so this flag stands one cycle less than count.
*/
`include "nv_access_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module nv_stall_timer (
    input wire clk,
    input wire rst_n,
    input wire load,
    input wire [2:0] count,
    output reg stall_reg
);
    reg [2:0] left_reg;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            left_reg <= 3'h0;
            stall_reg <= 1'b0;
        end else if (load) begin
            left_reg <= count - 3'h2;
            stall_reg <= 1'b1;
        end else if (left_reg != 3'h0) begin
            left_reg <= left_reg - 3'h1;
        end else begin
            stall_reg <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### design/nv_prog_timer.v
/*
 Program-time counter counting calibrated oscillator ticks.
 Assumes rc_tick is a one-cycle pulse per oscillator period; it keeps counting
 under a CPU reset so a running write finishes.
*/
`include "nv_access_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module nv_prog_timer (
    input wire clk,
    input wire por_n,
    input wire start,
    input wire rc_tick,
    output reg busy_reg,
    output reg done_reg
);
    reg [14:0] ticks_reg;
    always @(posedge clk or negedge por_n) begin
        if (!por_n) begin
            ticks_reg <= 15'h0000;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (start && !busy_reg) begin
                ticks_reg <= 15'h0000;
                busy_reg <= 1'b1;
            end else if (busy_reg && rc_tick) begin
                if (ticks_reg == `PROG_LAST_TICK) begin
                    busy_reg <= 1'b0;
                    done_reg <= 1'b1;
                end else begin
                    ticks_reg <= ticks_reg + 15'h0001;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### design/nv_access_ctrl.v
/*
 Nonvolatile byte-array access controller on the core I/O register bus:
 address, data and control registers, write arming, program timing, stalls.
 Assumes a single-cycle I/O bus from the core, the array model outside, and
 a power-on reset por_n separate from the system reset rst_n.
*/
// What this block does
// - Write continues and clock runs in power-down
// - Reset does not abort a running write
// - Small array: 9-bit address, upper bits zero
// - Large arrays: 11-bit address, bits 15:11 zero
// - Address undefined at reset; software loads it
// - Data register feeds writes, holds read byte
// - Ready request while write strobe clear, enabled
// - Write arm clears itself after four cycles
// - Write starts only within armed window
// - Read strobe fetches byte same instruction
// - Read stalls processor four cycles
// - Bit ops low I/O; memory view adds 0x20
// - Extended I/O reachable by data space only
// - Bit set, clear touch only addressed bit
// - Strobe clears after 27072 oscillator cycles
// - Ignore reads, address changes during write
// - Write start stalls processor two cycles
// - No write start during flash self-programming
`include "nv_access_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module nv_access_ctrl #(
    parameter LARGE_ARRAY = 1,
    parameter ADDR_BITS = 11
) (
    input wire clk,
    input wire rst_n,
    input wire por_n,
    input wire [7:0] io_addr,
    input wire io_data_space,
    input wire io_wr,
    input wire io_rd,
    input wire io_bit_set,
    input wire io_bit_clr,
    input wire [2:0] io_bit_sel,
    input wire [7:0] io_wdata,
    input wire global_irq_enable,
    input wire flash_selfprog_busy,
    input wire sleep_power_down,
    input wire [7:0] array_rdata,
    output reg [7:0] io_rdata,
    output reg io_hit,
    output reg cpu_stall,
    output reg nv_ready_irq,
    output reg nv_clock_hold,
    output reg array_rd,
    output reg array_wr,
    output reg [10:0] array_addr,
    output reg [7:0] array_wdata
);
    reg rst_meta_reg;
    reg rst_sync_reg;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    reg [10:0] nv_address_reg;
    reg [7:0] nv_data_byte_reg;
    reg nv_ready_irq_enable_reg;
    reg nv_master_write_arm_reg;
    reg nv_read_strobe_reg;
    reg [2:0] arm_count_reg;
    reg [1:0] rc_div_reg;
    reg rc_tick_reg;
    wire prog_busy;
    wire prog_done;
    wire read_stall;
    wire write_stall;

    // Map both the direct I/O number and the data-space view
    wire direct_ok = !io_data_space && (io_addr <= `IO_DIRECT_MAX);
    wire [7:0] io_num = io_data_space ? (io_addr - `IO_MEM_OFFSET) : io_addr;
    wire space_ok = direct_ok || (io_data_space && io_addr >= `IO_MEM_OFFSET
        && io_addr < `IO_EXT_LO);
    wire bit_ok = !io_data_space && (io_addr <= `IO_BIT_MAX);
    wire bit_op = (io_bit_set || io_bit_clr) && bit_ok;
    wire sel_ctl = space_ok && io_num == `OFF_CONTROL;
    wire sel_dat = space_ok && io_num == `OFF_DATA_BYTE;
    wire sel_lo = space_ok && io_num == `OFF_ADDR_LOW;
    wire sel_hi = space_ok && io_num == `OFF_ADDR_HIGH;
    wire [10:0] addr_mask = LARGE_ARRAY ? 11'h7ff : 11'h1ff;

    // Current control image, reserved bits zero
    wire [7:0] ctl_now = {4'h0, nv_ready_irq_enable_reg, nv_master_write_arm_reg,
        prog_busy, nv_read_strobe_reg};
    // Bit operations modify only the addressed bit
    reg [7:0] ctl_wr;
    always @* begin
        ctl_wr = ctl_now;
        if (io_wr && sel_ctl)
            ctl_wr = io_wdata;
        else if (bit_op && sel_ctl && io_bit_set)
            ctl_wr[io_bit_sel] = 1'b1;
        else if (bit_op && sel_ctl && io_bit_clr)
            ctl_wr[io_bit_sel] = 1'b0;
    end
    wire ctl_write = sel_ctl && (io_wr || bit_op);
    wire arm_set = ctl_write && ctl_wr[`CTL_ARM_BIT] && !nv_master_write_arm_reg;
    wire write_go = ctl_write && ctl_wr[`CTL_WRITE_BIT] && nv_master_write_arm_reg
        && !prog_busy && !flash_selfprog_busy;
    wire read_go = ctl_write && ctl_wr[`CTL_READ_BIT] && !prog_busy;

    always @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            nv_ready_irq_enable_reg <= 1'b0;
            nv_master_write_arm_reg <= 1'b0;
            nv_read_strobe_reg <= 1'b0;
            arm_count_reg <= 3'h0;
            nv_data_byte_reg <= `DATA_RESET;
        end else begin
            if (ctl_write)
                nv_ready_irq_enable_reg <= ctl_wr[`CTL_IRQEN_BIT];
            if (arm_set) begin
                nv_master_write_arm_reg <= 1'b1;
                arm_count_reg <= `ARM_WINDOW_CYCLES;
            end else if (nv_master_write_arm_reg) begin
                if (arm_count_reg == 3'h1 || write_go)
                    nv_master_write_arm_reg <= 1'b0;
                arm_count_reg <= arm_count_reg - 3'h1;
            end
            nv_read_strobe_reg <= 1'b0;
            if (read_go)
                nv_data_byte_reg <= array_rdata;
            else if (io_wr && sel_dat && !prog_busy)
                nv_data_byte_reg <= io_wdata;
        end
    end

    // Address is left undefined by reset; only writes load it
    always @(posedge clk) begin
        if (io_wr && sel_lo && !prog_busy)
            nv_address_reg[7:0] <= io_wdata;
        if (io_wr && sel_hi && !prog_busy)
            nv_address_reg[10:8] <= io_wdata[2:0] & addr_mask[10:8];
    end

    // Oscillator tick every second system clock, keeping the program time short
    always @(posedge clk or negedge por_n) begin
        if (!por_n) begin
            rc_div_reg <= 2'h0;
            rc_tick_reg <= 1'b0;
        end else begin
            rc_div_reg <= (rc_div_reg == `RC_DIV_LAST) ? 2'h0 : rc_div_reg + 2'h1;
            rc_tick_reg <= (rc_div_reg == `RC_DIV_LAST);
        end
    end

    // Program timer runs on power-on reset only, surviving system reset
    nv_prog_timer u_prog (
        .clk(clk),
        .por_n(por_n),
        .start(write_go),
        .rc_tick(rc_tick_reg),
        .busy_reg(prog_busy),
        .done_reg(prog_done)
    );

    nv_stall_timer u_rd_stall (
        .clk(clk),
        .rst_n(rst_sync_reg),
        .load(read_go),
        .count(`READ_STALL_CYCLES),
        .stall_reg(read_stall)
    );

    nv_stall_timer u_wr_stall (
        .clk(clk),
        .rst_n(rst_sync_reg),
        .load(write_go),
        .count(`WRITE_STALL_CYCLES),
        .stall_reg(write_stall)
    );

    // Registered outputs
    always @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            io_rdata <= 8'h00;
            io_hit <= 1'b0;
            cpu_stall <= 1'b0;
            nv_ready_irq <= 1'b0;
            array_rd <= 1'b0;
            array_wr <= 1'b0;
            array_addr <= 11'h000;
            array_wdata <= 8'h00;
        end else begin
            io_hit <= (io_rd || io_wr || bit_op) && (sel_ctl || sel_dat || sel_lo || sel_hi);
            if (io_rd && sel_ctl)
                io_rdata <= ctl_now;
            else if (io_rd && sel_dat)
                io_rdata <= read_go ? array_rdata : nv_data_byte_reg;
            else if (io_rd && sel_lo)
                io_rdata <= nv_address_reg[7:0];
            else if (io_rd && sel_hi)
                io_rdata <= {5'h00, nv_address_reg[10:8] & addr_mask[10:8]};
            else
                io_rdata <= 8'h00;
            cpu_stall <= read_go || write_go || (read_stall && !read_go) ||
                (write_stall && !write_go);
            nv_ready_irq <= nv_ready_irq_enable_reg && global_irq_enable &&
                !prog_busy && !write_go;
            array_rd <= read_go;
            array_wr <= write_go;
            if (write_go)
                array_wdata <= nv_data_byte_reg;
            if (!prog_busy)
                array_addr <= nv_address_reg & addr_mask;
        end
    end

    // Clock hold keeps the program clock alive through power-down
    always @(posedge clk or negedge por_n) begin
        if (!por_n)
            nv_clock_hold <= 1'b0;
        else
            nv_clock_hold <= sleep_power_down && (prog_busy || write_go) && !prog_done;
    end

endmodule
`default_nettype wire

// ### dv/nv_access_ctrl_properties.sv
/*
 Port-level timing checks for nv_access_ctrl.
 Assumes binding onto every nv_access_ctrl instance.
*/
`timescale 1ns/1ps
`default_nettype none
module nv_access_ctrl_properties #(
    parameter LARGE_ARRAY = 1,
    parameter ADDR_BITS = 11
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic por_n,
    input wire logic [7:0] io_addr,
    input wire logic io_data_space,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic io_bit_set,
    input wire logic io_bit_clr,
    input wire logic [2:0] io_bit_sel,
    input wire logic [7:0] io_wdata,
    input wire logic global_irq_enable,
    input wire logic flash_selfprog_busy,
    input wire logic sleep_power_down,
    input wire logic [7:0] array_rdata,
    input wire logic [7:0] io_rdata,
    input wire logic io_hit,
    input wire logic cpu_stall,
    input wire logic nv_ready_irq,
    input wire logic nv_clock_hold,
    input wire logic array_rd,
    input wire logic array_wr,
    input wire logic [10:0] array_addr,
    input wire logic [7:0] array_wdata
);
default clocking @(posedge clk); endclocking
default disable iff (!rst_n);
wire ctl_acc = io_data_space ? (io_addr == 8'h3f) : (io_addr == 8'h1f);
a_ctl_upper_zero: assert property (io_rd && ctl_acc |=> io_rdata[7:4] == 4'h0 && !io_rdata[0])
    else $error("control reserved bits or read strobe not zero");
a_read_stall: assert property (array_rd |-> cpu_stall [*4] ##1 !cpu_stall)
    else $error("read stall length wrong");
a_write_stall: assert property (array_wr |-> cpu_stall [*2] ##1 !cpu_stall)
    else $error("write stall length wrong");
a_write_cause: assert property (array_wr |-> !$past(flash_selfprog_busy) &&
    $past(io_wr && io_wdata[1] || io_bit_set && io_bit_sel == 3'h1)) else $error("write without strobe");
a_read_cause: assert property (array_rd |->
    $past(io_wr && io_wdata[0] || io_bit_set && io_bit_sel == 3'h0)) else $error("read without strobe");
a_irq_drop: assert property (array_wr |-> ##[1:2] !nv_ready_irq)
    else $error("ready request during write");
a_ext_miss: assert property ((io_wr || io_rd) && io_data_space && io_addr >= 8'h60 |=> !io_hit)
    else $error("extended space hit");
a_bit_high_miss: assert property ((io_bit_set || io_bit_clr) && !io_data_space && io_addr > 8'h1f |=> !io_hit)
    else $error("bit op above bit range hit");
a_hold_cause: assert property (nv_clock_hold |-> $past(sleep_power_down))
    else $error("clock hold without power-down");
endmodule
bind nv_access_ctrl nv_access_ctrl_properties #(.LARGE_ARRAY(LARGE_ARRAY), .ADDR_BITS(ADDR_BITS)) chk (
    .clk(clk), .rst_n(rst_n), .por_n(por_n), .io_addr(io_addr), .io_data_space(io_data_space),
    .io_wr(io_wr), .io_rd(io_rd), .io_bit_set(io_bit_set), .io_bit_clr(io_bit_clr),
    .io_bit_sel(io_bit_sel), .io_wdata(io_wdata), .global_irq_enable(global_irq_enable),
    .flash_selfprog_busy(flash_selfprog_busy), .sleep_power_down(sleep_power_down),
    .array_rdata(array_rdata), .io_rdata(io_rdata), .io_hit(io_hit), .cpu_stall(cpu_stall),
    .nv_ready_irq(nv_ready_irq), .nv_clock_hold(nv_clock_hold), .array_rd(array_rd),
    .array_wr(array_wr), .array_addr(array_addr), .array_wdata(array_wdata)
);
`default_nettype wire

// ### dv/nv_array_model.sv
/*
 Byte array behind the controller.
 Assumes read data follows the address of the prior cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module nv_array_model (
    input wire logic clk,
    input wire logic array_wr,
    input wire logic [10:0] array_addr,
    input wire logic [7:0] array_wdata,
    output logic [7:0] array_rdata
);
logic [7:0] cells [0:2047];
logic [10:0] addr_q;
always @(posedge clk) begin
    addr_q <= array_addr;
    if (array_wr)
        cells[array_addr] <= array_wdata;
end
assign array_rdata = cells[addr_q];
endmodule
`default_nettype wire

// ### dv/tb_nv_access_ctrl.sv
/*
 Self-checking bench for nv_access_ctrl.
 Assumes design, checker and array model compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_nv_access_ctrl;
localparam logic [8:0] CTL = 9'h01f, DAT = 9'h020, AL = 9'h021, AH = 9'h022;
logic clk = 0, rst_n = 0, por_n = 0, io_data_space = 0, io_wr = 0, io_rd = 0, io_bit_set = 0, io_bit_clr = 0;
logic global_irq_enable = 0, flash_selfprog_busy = 0, sleep_power_down = 0;
logic [7:0] io_addr = 8'h00, io_wdata = 8'h00, array_rdata, io_rdata, array_wdata;
logic [2:0] io_bit_sel = 3'h0;
logic [10:0] array_addr;
logic io_hit, cpu_stall, nv_ready_irq, nv_clock_hold, array_rd, array_wr;
logic [7:0] io_rdata_s;
int error_cnt = 0;
int checks = 0;
int cyc = 0;
// Program time: 27072 oscillator ticks, one tick every second clock in this design
localparam int PROG_CYC = 27072 * 2;
always @(posedge clk) cyc <= cyc + 1;
nv_access_ctrl #(.LARGE_ARRAY(1), .ADDR_BITS(11)) dut (
    .clk(clk), .rst_n(rst_n), .por_n(por_n), .io_addr(io_addr), .io_data_space(io_data_space),
    .io_wr(io_wr), .io_rd(io_rd), .io_bit_set(io_bit_set), .io_bit_clr(io_bit_clr),
    .io_bit_sel(io_bit_sel), .io_wdata(io_wdata), .global_irq_enable(global_irq_enable),
    .flash_selfprog_busy(flash_selfprog_busy), .sleep_power_down(sleep_power_down),
    .array_rdata(array_rdata), .io_rdata(io_rdata), .io_hit(io_hit), .cpu_stall(cpu_stall),
    .nv_ready_irq(nv_ready_irq), .nv_clock_hold(nv_clock_hold), .array_rd(array_rd),
    .array_wr(array_wr), .array_addr(array_addr), .array_wdata(array_wdata)
);
// Smallest array variant, same stimulus, only its read data is judged
nv_access_ctrl #(.LARGE_ARRAY(0), .ADDR_BITS(9)) dut_small (
    .clk(clk), .rst_n(rst_n), .por_n(por_n), .io_addr(io_addr), .io_data_space(io_data_space),
    .io_wr(io_wr), .io_rd(io_rd), .io_bit_set(io_bit_set), .io_bit_clr(io_bit_clr),
    .io_bit_sel(io_bit_sel), .io_wdata(io_wdata), .global_irq_enable(global_irq_enable),
    .flash_selfprog_busy(flash_selfprog_busy), .sleep_power_down(sleep_power_down),
    .array_rdata(array_rdata), .io_rdata(io_rdata_s), .io_hit(), .cpu_stall(),
    .nv_ready_irq(), .nv_clock_hold(), .array_rd(),
    .array_wr(), .array_addr(), .array_wdata()
);
nv_array_model mem (
    .clk(clk),
    .array_wr(array_wr),
    .array_addr(array_addr),
    .array_wdata(array_wdata),
    .array_rdata(array_rdata)
);
task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
        error_cnt++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
// Op 0 write, 1 read, 2 bit set, 3 bit clear; a holds data-space flag and address
task automatic acc(input logic [1:0] op, input logic [8:0] a, input logic [7:0] d);
    @(negedge clk);
    while (cpu_stall === 1'b1) @(negedge clk);
    {io_data_space, io_addr} = a;
    io_wdata = d;
    io_bit_sel = d[2:0];
    {io_wr, io_rd, io_bit_set, io_bit_clr} = 4'h8 >> op;
    @(negedge clk);
    {io_wr, io_rd, io_bit_set, io_bit_clr} = 4'h0;
endtask
task automatic rd(input logic [8:0] a, input logic [7:0] exp);
    acc(2'd1, a, 8'h00);
    chk(io_rdata, exp);
endtask
task automatic t_regs;
    acc(2'd0, AL, 8'h23);
    acc(2'd0, AH, 8'hff);
    rd(9'h142, 8'h07);
    chk(io_rdata_s, 8'h01);
    rd(9'h141, 8'h23);
    acc(2'd2, AL, 8'h07);
    rd(AL, 8'h23);
    acc(2'd0, CTL, 8'hf0);
    rd(CTL, 8'h00);
    chk({7'h0, io_hit}, 8'h01);
    rd(9'h160, 8'h00);
    chk({7'h0, io_hit}, 8'h00);
    acc(2'd2, CTL, 8'h03);
    rd(CTL, 8'h08);
    acc(2'd3, CTL, 8'h03);
    rd(CTL, 8'h00);
endtask
task automatic t_refuse;
    acc(2'd0, CTL, 8'h02);
    rd(CTL, 8'h00);
    acc(2'd2, CTL, 8'h02);
    rd(CTL, 8'h04);
    rd(CTL, 8'h04);
    rd(CTL, 8'h00);
    acc(2'd2, CTL, 8'h01);
    rd(CTL, 8'h00);
    flash_selfprog_busy = 1;
    acc(2'd2, CTL, 8'h02);
    acc(2'd2, CTL, 8'h01);
    acc(2'd1, CTL, 8'h00);
    chk(io_rdata & 8'h02, 8'h00);
    flash_selfprog_busy = 0;
    repeat (5) @(negedge clk);
endtask
task automatic t_write;
    int n = 0;
    int t0;
    acc(2'd0, AH, 8'h01);
    acc(2'd0, AL, 8'h23);
    acc(2'd0, DAT, 8'ha5);
    global_irq_enable = 1;
    acc(2'd0, CTL, 8'h08);
    @(negedge clk);
    chk({7'h0, nv_ready_irq}, 8'h01);
    acc(2'd2, CTL, 8'h02);
    acc(2'd2, CTL, 8'h01);
    t0 = cyc;
    rd(CTL, 8'h0a);
    chk({7'h0, nv_ready_irq}, 8'h00);
    acc(2'd0, AL, 8'h55);
    rd(AL, 8'h23);
    acc(2'd0, CTL, 8'h09);
    rd(DAT, 8'ha5);
    sleep_power_down = 1;
    repeat (4) @(negedge clk);
    chk({7'h0, nv_clock_hold}, 8'h01);
    sleep_power_down = 0;
    rst_n = 0;
    repeat (3) @(negedge clk);
    rst_n = 1;
    repeat (4) @(negedge clk);
    rd(CTL, 8'h02);
    do begin
        repeat (100) @(negedge clk);
        acc(2'd1, CTL, 8'h00);
        n++;
    end while (io_rdata[1] !== 1'b0 && n < 600);
    chk({7'h0, io_rdata[1]}, 8'h00);
    chk((cyc - t0 >= PROG_CYC - 1 && cyc - t0 < PROG_CYC + 110) ? 8'h01 : 8'h00, 8'h01);
    sleep_power_down = 1;
    repeat (2) @(negedge clk);
    chk({7'h0, nv_clock_hold}, 8'h00);
    sleep_power_down = 0;
    chk(mem.cells[11'h123], 8'ha5);
    acc(2'd0, DAT, 8'h00);
    acc(2'd0, CTL, 8'h01);
    rd(DAT, 8'ha5);
    acc(2'd0, CTL, 8'h08);
    @(negedge clk);
    chk({7'h0, nv_ready_irq}, 8'h01);
endtask
task automatic print_verdict;
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
        $display("NO MISMATCHES");
    else
        $display("MISMATCHES SEEN");
    $finish;
endtask
initial begin
    forever #10 clk = ~clk;
end
initial begin
    repeat (80000) @(posedge clk);
    error_cnt++;
    print_verdict;
end
initial begin
    repeat (8) @(negedge clk);
    por_n = 1;
    rst_n = 1;
    repeat (4) @(negedge clk);
    t_regs;
    t_refuse;
    t_write;
    print_verdict;
end
endmodule
`default_nettype wire
